// ===== rtl/ext_bus_pkg.sv
// Constants for the external bus ready and wait-state block
package ext_bus_pkg;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 32;
   localparam int WAIT_W = 3;
   localparam int BANK_W = 5;
   // Register byte offsets
   localparam logic [7:0] OFS_BUS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_EXT_ADDR = 8'h08;
   localparam logic [7:0] OFS_EXT_WDATA = 8'h0C;
   localparam logic [7:0] OFS_EXT_RDATA = 8'h10;
   // Bus control fields
   localparam int RSEL_LSB = 3;
   localparam int WCNT_LSB = 5;
   localparam int BCMP_LSB = 8;
   localparam logic [1:0] RSEL_RESET = 2'h3;
   localparam logic [WAIT_W-1:0] WCNT_RESET = 3'h7;
   localparam logic [BANK_W-1:0] BCMP_RESET = 5'h00;
   // Ready select codes
   localparam logic [1:0] RSEL_PIN = 2'h0;
   localparam logic [1:0] RSEL_CNT = 2'h1;
   localparam logic [1:0] RSEL_EITHER = 2'h2;
   localparam logic [1:0] RSEL_BOTH = 2'h3;
   // Bus clock phase: one enable pulse every BUS_PHASE_DIV clocks
   localparam int BUS_PHASE_DIV = 2;
   typedef enum logic [1:0] {ST_IDLE, ST_NULL, ST_ACC} bus_state_t;
endpackage

// ===== rtl/ext_bus_ready_waitstate.sv
// External bus ready merge, wait states, bank null cycle and posted writes
//
// Notes on behaviour
// - Ready sampled on bus clock phase edge.
// - Bits 4:3 choose the ready combination.
// - Select 00: only the ready pin counts.
// - Select 01: only the wait counter counts.
// - Select 10: pin low ends, else counter.
// - Select resets to 11: pin and counter.
// - Mode 11, pin low: counter alone times.
// - Mode 11, pin high: stretch, never shorter.
// - Bank change before read adds null cycle.
// - Writes never get the null cycle.
// - Write address and data held until done.
// - One posted write; software need not stall.
// - Undriven data pins keep last level.
// - Keeper on unless hiz held low or a write drives the data pins.
// - One control register for every access.
`timescale 1ns/100ps
module ext_bus_ready_waitstate
   import ext_bus_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // External bus pins
   input wire logic ready_n_i,
   input wire logic pin_hiz_control_n_i,
   output logic [ADDR_W-1:0] ext_addr_o,
   output logic ext_strb_n_o,
   output logic ext_rd_o,
   output logic ext_pins_oe_n_o,
   input wire logic [DATA_W-1:0] ext_data_i,
   output logic [DATA_W-1:0] ext_data_o,
   output logic ext_data_oe_n_o,
   output logic [DATA_W-1:0] ext_keep_o,
   output logic ext_keep_en_o
);
   // Bank of an address: the top 'width' bits, width 0 means no check
   function automatic logic [ADDR_W-1:0] bank_of(input logic [ADDR_W-1:0] a,
                                                  input logic [BANK_W-1:0] width);
      logic [ADDR_W-1:0] mask;
      mask = ~({ADDR_W{1'b1}} >> width);
      return a & mask;
   endfunction

   logic [1:0] rsel_q;
   logic [WAIT_W-1:0] wcnt_q;
   logic [BANK_W-1:0] bcmp_q;
   logic [ADDR_W-1:0] ext_addr_q;
   logic [ADDR_W-1:0] cur_addr_q;
   logic [ADDR_W-1:0] last_addr_q;
   logic cur_wr_q;
   logic phase_q;
   logic ack_q;
   logic rd_pend_q;
   logic [31:0] dat_q;
   logic [DATA_W-1:0] keep_q;
   bus_state_t state_q;
   bus_state_t state_d;

   wire phase = phase_q;
   wire hiz = ~pin_hiz_control_n_i;
   wire stb_hit = cyc_i & stb_i & ~ack_q;
   wire all_sel = (sel_i == 4'hF);
   wire hit_ctrl = (adr_i == OFS_BUS_CTRL);
   wire hit_stat = (adr_i == OFS_STATUS);
   wire hit_addr = (adr_i == OFS_EXT_ADDR);
   wire hit_wdat = (adr_i == OFS_EXT_WDATA);
   wire hit_rdat = (adr_i == OFS_EXT_RDATA);

   wire wb_valid;
   wire wb_ready;
   wire [ADDR_W-1:0] wb_addr;
   wire [DATA_W-1:0] wb_data;
   wire cnt_zero;

   // Ready merge, all signals active high inside
   wire pin_rdy = ~ready_n_i;
   logic rdy_ok;
   always_comb begin
      case (rsel_q)
         RSEL_PIN: rdy_ok = pin_rdy;
         RSEL_CNT: rdy_ok = cnt_zero;
         RSEL_EITHER: rdy_ok = pin_rdy | cnt_zero;
         default: rdy_ok = pin_rdy & cnt_zero;
      endcase
   end

   wire in_acc = (state_q == ST_ACC);
   wire fin = phase & in_acc & rdy_ok;
   wire wr_pop = fin & cur_wr_q;
   wire rd_done = fin & ~cur_wr_q;
   wire bank_chg = (bcmp_q != '0) &&
                   (bank_of(ext_addr_q, bcmp_q) != bank_of(last_addr_q, bcmp_q));
   wire start_acc = phase & (state_d == ST_ACC) & (state_q != ST_ACC);

   // Posted write: taken at once while the holding slot is free
   wire wr_push = stb_hit & we_i & hit_wdat & wb_ready;
   wire rd_start = stb_hit & ~we_i & hit_rdat & ~rd_pend_q & ~rd_done;
   wire reg_go = ~(hit_wdat & we_i) & ~(hit_rdat & ~we_i);
   wire ack_d = stb_hit & ((we_i & hit_wdat & wb_ready) | (hit_rdat & ~we_i & rd_done) | reg_go);

   logic [31:0] rd_mux;
   always_comb begin
      if (hit_ctrl) begin
         rd_mux = {19'h0, bcmp_q, wcnt_q, rsel_q, 3'h0};
      end else if (hit_stat) begin
         rd_mux = {27'h0, hiz, rd_pend_q, wb_valid, in_acc, phase};
      end else if (hit_addr) begin
         rd_mux = {8'h00, ext_addr_q};
      end else if (hit_wdat) begin
         rd_mux = wb_data;
      end else if (hit_rdat) begin
         rd_mux = ext_data_i;
      end else begin
         rd_mux = 32'h0;
      end
   end

   // Bus clock phase divider
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_q <= 1'b0;
      end else begin
         phase_q <= ~phase_q;
      end
   end

   // Single control register covers every page
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rsel_q <= RSEL_RESET;
         wcnt_q <= WCNT_RESET;
         bcmp_q <= BCMP_RESET;
         ext_addr_q <= '0;
      end else if (stb_hit & we_i & all_sel) begin
         if (hit_ctrl) begin
            rsel_q <= dat_i[RSEL_LSB +: 2];
            wcnt_q <= dat_i[WCNT_LSB +: WAIT_W];
            bcmp_q <= dat_i[BCMP_LSB +: BANK_W];
         end else if (hit_addr) begin
            ext_addr_q <= dat_i[ADDR_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= '0;
         rd_pend_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
         if (ack_d) begin
            dat_q <= rd_mux;
         end
         if (rd_start) begin
            rd_pend_q <= 1'b1;
         end else if (rd_done) begin
            rd_pend_q <= 1'b0;
         end
      end
   end

   // Sequencer; steps only on bus clock phase, no access starts while pins are off
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (!hiz && wb_valid) begin
               state_d = ST_ACC;
            end else if (!hiz && rd_pend_q) begin
               state_d = bank_chg ? ST_NULL : ST_ACC;
            end
         end
         ST_NULL: state_d = ST_ACC;
         default: state_d = rdy_ok ? ST_IDLE : ST_ACC;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         cur_addr_q <= '0;
         cur_wr_q <= 1'b0;
         last_addr_q <= '0;
      end else if (phase) begin
         state_q <= state_d;
         if (state_q == ST_IDLE && state_d != ST_IDLE) begin
            cur_wr_q <= wb_valid;
            cur_addr_q <= wb_valid ? wb_addr : ext_addr_q;
         end
         if (fin) begin
            last_addr_q <= cur_addr_q;
         end
      end
   end

   // Keeper follows whatever was last on the pins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         keep_q <= '0;
      end else begin
         keep_q <= ~ext_data_oe_n_o ? wb_data : ext_data_i;
      end
   end

   wait_counter u_wait (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(start_acc),
      .load_val_i(wcnt_q),
      .tick_i(phase & in_acc),
      .zero_o(cnt_zero)
   );

   write_post_buffer u_wbuf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .push_i(wr_push),
      .addr_i(ext_addr_q),
      .data_i(dat_i),
      .pop_i(wr_pop),
      .valid_o(wb_valid),
      .ready_o(wb_ready),
      .addr_o(wb_addr),
      .data_o(wb_data)
   );

   assign ack_o = ack_q;
   assign dat_o = dat_q;
   assign ext_addr_o = cur_addr_q;
   assign ext_data_o = wb_data;
   assign ext_strb_n_o = ~(in_acc & ~hiz);
   assign ext_rd_o = ~cur_wr_q;
   assign ext_pins_oe_n_o = hiz;
   assign ext_data_oe_n_o = ~(in_acc & cur_wr_q & ~hiz);
   assign ext_keep_o = keep_q;
   assign ext_keep_en_o = ~hiz & ext_data_oe_n_o;

   AST_SAMPLE_ON_PHASE: assert property (@(posedge clk_i) disable iff (rst_i)
      !phase_q |=> $stable(state_q)) else $error("sequencer moved off the bus clock phase");
   AST_RSEL_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> rsel_q == 2'h3) else $error("ready select not 11 after reset");
   AST_PIN_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
      (phase && in_acc && rsel_q == RSEL_PIN) |-> (fin == !ready_n_i))
      else $error("pin only mode did not follow ready pin");
   AST_CNT_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
      (phase && in_acc && rsel_q == RSEL_CNT) |-> (fin == cnt_zero))
      else $error("counter only mode did not follow counter");
   AST_EITHER_FAST: assert property (@(posedge clk_i) disable iff (rst_i)
      (phase && in_acc && rsel_q == RSEL_EITHER && !ready_n_i) |-> fin)
      else $error("low ready pin did not end access");
   AST_BOTH_MIN_WAIT: assert property (@(posedge clk_i) disable iff (rst_i)
      (fin && rsel_q == RSEL_BOTH) |-> (cnt_zero && !ready_n_i))
      else $error("combined mode ended early");
   AST_BOTH_PIN_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
      (phase && in_acc && rsel_q == RSEL_BOTH && !ready_n_i && cnt_zero) |-> fin)
      else $error("combined mode ignored counter zero");
   AST_NULL_ONE_PHASE: assert property (@(posedge clk_i) disable iff (rst_i)
      (phase && state_q == ST_NULL) |=> (state_q == ST_ACC && !cur_wr_q))
      else $error("null cycle not followed by read access");
   AST_NULL_NOT_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      (phase && state_q == ST_IDLE && !hiz && wb_valid) |=> (state_q == ST_ACC && cur_wr_q))
      else $error("null cycle before a write");
   AST_WRITE_HELD: assert property (@(posedge clk_i) disable iff (rst_i)
      (in_acc && cur_wr_q && !fin) |=> ($stable(ext_addr_o) && $stable(ext_data_o)))
      else $error("posted write changed before completion");
   AST_POST_NO_STALL: assert property (@(posedge clk_i) disable iff (rst_i)
      (stb_hit && we_i && hit_wdat && !wb_valid) |=> ack_o)
      else $error("posted write stalled with empty slot");
   AST_KEEPER_HIZ: assert property (@(posedge clk_i) disable iff (rst_i)
      !pin_hiz_control_n_i |-> (!ext_keep_en_o && ext_data_oe_n_o))
      else $error("pins active under hiz control");
   AST_COUNT_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
      (start_acc && wcnt_q != '0) |=> !cnt_zero ##1 !cnt_zero)
      else $error("wait counter did not load");
   AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o) else $error("ack longer than one cycle");
   AST_RESET_OUTS: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> (ext_strb_n_o && ext_data_oe_n_o && !ack_o && ext_addr_o == '0))
      else $error("bus pins or ack active after reset");
   AST_NO_REQ_NO_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
      !(cyc_i && stb_i) |=> !ack_o)
      else $error("ack without a request");
   AST_RDATA_WAITS: assert property (@(posedge clk_i) disable iff (rst_i)
      (stb_hit && !we_i && hit_rdat && !rd_done) |=> !ack_o)
      else $error("external read acked before it ended");
   AST_FULL_WAITS: assert property (@(posedge clk_i) disable iff (rst_i)
      (stb_hit && we_i && hit_wdat && wb_valid) |=> !ack_o)
      else $error("posted write taken while slot full");
   AST_EITHER_WAIT: assert property (@(posedge clk_i) disable iff (rst_i)
      (phase && in_acc && rsel_q == RSEL_EITHER && ready_n_i) |-> (fin == cnt_zero))
      else $error("high ready pin did not leave timing to counter");
   AST_BOTH_STRETCH: assert property (@(posedge clk_i) disable iff (rst_i)
      (phase && in_acc && rsel_q == RSEL_BOTH && ready_n_i) |-> !fin)
      else $error("combined mode ended while ready pin high");
   AST_ZERO_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
      (start_acc && wcnt_q == '0) |=> cnt_zero)
      else $error("zero wait count did not give internal ready");
   AST_NULL_ON_CHANGE: assert property (@(posedge clk_i) disable iff (rst_i)
      (phase && state_q == ST_IDLE && !hiz && !wb_valid && rd_pend_q && bank_chg)
      |=> state_q == ST_NULL)
      else $error("bank change read without null cycle");
   AST_SAME_BANK_DIRECT: assert property (@(posedge clk_i) disable iff (rst_i)
      (phase && state_q == ST_IDLE && !hiz && !wb_valid && rd_pend_q && !bank_chg)
      |=> state_q == ST_ACC)
      else $error("same bank read delayed");
   AST_HIZ_NO_START: assert property (@(posedge clk_i) disable iff (rst_i)
      (!pin_hiz_control_n_i && state_q == ST_IDLE) |=> state_q == ST_IDLE)
      else $error("access started under hiz control");
   AST_ACC_SPACING: assert property (@(posedge clk_i) disable iff (rst_i)
      fin |=> !in_acc ##1 !in_acc)
      else $error("accesses not separated by an idle phase");
   AST_ACCESS_HELD: assert property (@(posedge clk_i) disable iff (rst_i)
      (in_acc && !fin) |=> (in_acc && $stable(ext_addr_o) && $stable(ext_rd_o)))
      else $error("access address or direction changed");
   AST_WRITE_DRIVES: assert property (@(posedge clk_i) disable iff (rst_i)
      (in_acc && cur_wr_q && !hiz) |-> (!ext_data_oe_n_o && !ext_rd_o))
      else $error("write access not driving data");
   AST_READ_NO_DRIVE: assert property (@(posedge clk_i) disable iff (rst_i)
      (in_acc && !cur_wr_q) |-> (ext_rd_o && ext_data_oe_n_o))
      else $error("read access driving data pins");
   AST_KEEP_LAST: assert property (@(posedge clk_i) disable iff (rst_i)
      !ext_data_oe_n_o |=> (ext_keep_o == $past(ext_data_o)))
      else $error("keeper lost last driven value");
   AST_KEEPER_ON: assert property (@(posedge clk_i) disable iff (rst_i)
      (pin_hiz_control_n_i && ext_data_oe_n_o) |-> ext_keep_en_o)
      else $error("keeper off while pins idle");

   COV_WRITE: cover property (@(posedge clk_i) disable iff (rst_i) wr_pop);
   COV_NULL_READ: cover property (@(posedge clk_i) disable iff (rst_i)
      state_q == ST_NULL ##[1:40] rd_done);
   COV_STRETCH: cover property (@(posedge clk_i) disable iff (rst_i)
      (in_acc && rsel_q == RSEL_BOTH && cnt_zero && ready_n_i) ##[1:40] fin);
   COV_FULL_WAIT: cover property (@(posedge clk_i) disable iff (rst_i)
      stb_hit && we_i && hit_wdat && wb_valid);
   COV_HIZ_HOLD: cover property (@(posedge clk_i) disable iff (rst_i)
      !pin_hiz_control_n_i && wb_valid);
endmodule

// ===== rtl/wait_counter.sv
// Internal wait-state counter, loaded per access, counts bus clock phases
`timescale 1ns/100ps
module wait_counter
   import ext_bus_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic [WAIT_W-1:0] load_val_i,
   input wire logic tick_i,
   output logic zero_o
);
   logic [WAIT_W-1:0] cnt_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
      end else if (load_i) begin
         cnt_q <= load_val_i;
      end else if (tick_i && cnt_q != '0) begin
         cnt_q <= cnt_q - 3'h1;
      end
   end

   assign zero_o = (cnt_q == '0);
endmodule

// ===== rtl/write_post_buffer.sv
// Single-entry posted write holding register
`timescale 1ns/100ps
module write_post_buffer
   import ext_bus_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic push_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] data_i,
   input wire logic pop_i,
   output logic valid_o,
   output logic ready_o,
   output logic [ADDR_W-1:0] addr_o,
   output logic [DATA_W-1:0] data_o
);
   logic valid_q;

   // Push wins over pop; a push while full overwrites the entry, so callers gate push with ready_o
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         valid_q <= 1'b0;
      end else if (push_i) begin
         valid_q <= 1'b1;
      end else if (pop_i) begin
         valid_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_o <= '0;
         data_o <= '0;
      end else if (push_i) begin
         addr_o <= addr_i;
         data_o <= data_i;
      end
   end

   assign valid_o = valid_q;
   assign ready_o = ~valid_q;
endmodule

// ===== verif/ext_bus_partner.sv
// Behavioural external memory with a ready pin held off for a set number of phases
`timescale 1ns/100ps
module ext_bus_partner
   import ext_bus_pkg::*;
(
   input wire logic clk_i,
   input wire logic [1:0] slow_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic strb_n_i,
   input wire logic rd_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wdata_oe_n_i,
   input wire logic [DATA_W-1:0] keep_i,
   input wire logic keep_en_i,
   output logic ready_n_o,
   output logic [DATA_W-1:0] data_o,
   output logic [ADDR_W-1:0] wr_addr_o,
   output logic [DATA_W-1:0] wr_data_o,
   output logic [7:0] wr_cnt_o,
   output logic hold_err_o
);
   logic [3:0] cnt_q = 4'h0;
   logic strb_n_q = 1'b1;
   logic [DATA_W-1:0] last_q = 32'h0;
   logic [ADDR_W-1:0] a_q;
   logic [DATA_W-1:0] d_q;
   initial begin
      wr_cnt_o = 8'h00;
      hold_err_o = 1'b0;
   end
   // Ready stays high for slow_i bus phases of each access
   assign ready_n_o = (cnt_q < {1'b0, slow_i, 1'b0});
   // Undriven pins with the keeper off drift away from the last level
   always_comb begin
      if (!wdata_oe_n_i) data_o = wdata_i;
      else if (!strb_n_i && rd_i) data_o = {8'h5A, addr_i};
      else if (keep_en_i) data_o = keep_i;
      else data_o = ~last_q;
   end
   always @(posedge clk_i) begin
      last_q <= data_o;
      strb_n_q <= strb_n_i;
      a_q <= addr_i;
      d_q <= wdata_i;
      cnt_q <= strb_n_i ? 4'h0 : cnt_q + 4'h1;
      if (!strb_n_i && !strb_n_q && (addr_i != a_q || (!rd_i && wdata_i != d_q)))
         hold_err_o <= 1'b1;
      if (!strb_n_i && !rd_i) begin
         wr_addr_o <= addr_i;
         wr_data_o <= wdata_i;
      end
      if (!strb_n_i && strb_n_q && !rd_i) wr_cnt_o <= wr_cnt_o + 8'h01;
   end
endmodule

// ===== verif/tb.sv
// Register-level bench for the external bus ready and wait-state block
`timescale 1ns/100ps
module tb;
   import ext_bus_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0, dat_o, q;
   logic ack_o, ready_n, strb_n, rd, pins_oe_n, data_oe_n, keep_en, hold_err;
   logic hiz_n = 1'b1;
   logic [1:0] slow = 2'h0;
   logic [ADDR_W-1:0] ext_addr, wr_addr;
   logic [DATA_W-1:0] ext_din, ext_dout, keep, wr_data;
   logic [7:0] wr_cnt;
   int error_cnt = 0, n_checks = 0, cyc_cnt = 0, run_len = 0, low_len = 0;
   int fall_t = 0, t0 = 0, wait_n = 0, e = 0, ls = 0;
   ext_bus_ready_waitstate DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .ready_n_i(ready_n), .pin_hiz_control_n_i(hiz_n), .ext_addr_o(ext_addr),
      .ext_strb_n_o(strb_n), .ext_rd_o(rd), .ext_pins_oe_n_o(pins_oe_n), .ext_data_i(ext_din),
      .ext_data_o(ext_dout), .ext_data_oe_n_o(data_oe_n), .ext_keep_o(keep),
      .ext_keep_en_o(keep_en));
   ext_bus_partner mem (.clk_i(clk_i), .slow_i(slow), .addr_i(ext_addr), .strb_n_i(strb_n),
      .rd_i(rd), .wdata_i(ext_dout), .wdata_oe_n_i(data_oe_n), .keep_i(keep),
      .keep_en_i(keep_en), .ready_n_o(ready_n), .data_o(ext_din), .wr_addr_o(wr_addr),
      .wr_data_o(wr_data), .wr_cnt_o(wr_cnt), .hold_err_o(hold_err));
   initial forever #5 clk_i = ~clk_i;
   // Strobe-low length and the cycle of its falling edge
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      run_len <= strb_n ? 0 : run_len + 1;
      if (!strb_n && run_len == 0) fall_t <= cyc_cnt;
      if (strb_n && run_len != 0) low_len <= run_len;
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Requests launch on even cycles so phase alignment is repeatable
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      while (cyc_cnt[0]) @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      t0 = cyc_cnt;
      wait_n = 0;
      do begin
         @(posedge clk_i);
         wait_n++;
      end while (ack_o !== 1'b1 && wait_n < 300);
      if (wait_n >= 300) check("ack_timeout", 32'h1, 32'h0);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic rd_lead(input logic [23:0] a);
      repeat (4) @(posedge clk_i);
      wb(1'b1, OFS_EXT_ADDR, {8'h00, a});
      wb(1'b0, OFS_EXT_RDATA, 32'h0);
      ls = fall_t - t0;
   endtask
   task automatic wr_lead(input logic [23:0] a);
      wb(1'b1, OFS_EXT_ADDR, {8'h00, a});
      wb(1'b1, OFS_EXT_WDATA, 32'h11110000);
      repeat (20) @(posedge clk_i);
      ls = fall_t - t0;
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #200us;
      error_cnt++;
      conclude();
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, OFS_BUS_CTRL, 32'h0);
      check("ctrl_reset", q, 32'h000000F8);
      wb(1'b0, 8'h20, 32'h0);
      check("unmapped", q, 32'h0);
      $display("test reset done");
      for (int m = 0; m < 4; m++) begin
         for (int s = 0; s < 3; s += 2) begin
            slow <= 2'(s);
            wb(1'b1, OFS_BUS_CTRL, 32'(m << 3) | 32'h20);
            rd_lead({2'(m), 22'h10 + 22'(s)});
            check("rd_data", q, {8'h5A, 2'(m), 22'h10 + 22'(s)});
            repeat (2) @(posedge clk_i);
            e = (m == 0) ? 2 * (s + 1) : (m == 1) ? 4 : (m == 2) ? ((s == 0) ? 2 : 4) : 2 * s + 2;
            if (m == 3 && s == 0) e = 4;
            check("acc_len", 32'(low_len), 32'(e));
         end
      end
      $display("test ready modes done");
      slow <= 2'h3;
      wb(1'b1, OFS_BUS_CTRL, 32'h0);
      wb(1'b1, OFS_EXT_ADDR, 32'h00123456);
      wb(1'b1, OFS_EXT_WDATA, 32'hCAFE0001);
      check("post_ack", 32'(wait_n), 32'h2);
      wb(1'b1, OFS_EXT_ADDR, 32'h00654321);
      wb(1'b1, OFS_EXT_WDATA, 32'hCAFE0002);
      check("second_waits", 32'(wait_n > 2), 32'h1);
      repeat (30) @(posedge clk_i);
      check("wr_addr", {8'h00, wr_addr}, 32'h00654321);
      check("wr_data", wr_data, 32'hCAFE0002);
      check("hold", {31'h0, hold_err}, 32'h0);
      check("wr_cnt", {24'h0, wr_cnt}, 32'h2);
      check("keep_val", keep, 32'hCAFE0002);
      check("keep_en", {31'h0, keep_en}, 32'h1);
      $display("test posted writes done");
      slow <= 2'h0;
      wb(1'b1, OFS_BUS_CTRL, 32'h00000108);
      rd_lead(24'h000010);
      rd_lead(24'h000020);
      e = ls;
      rd_lead(24'h800020);
      check("null_rd", 32'(ls), 32'(e + 2));
      wr_lead(24'h800040);
      e = ls;
      wr_lead(24'h000030);
      check("null_wr", 32'(ls), 32'(e));
      $display("test bank compare done");
      hiz_n <= 1'b0;
      repeat (2) @(posedge clk_i);
      check("hiz_keep", {31'h0, keep_en}, 32'h0);
      check("hiz_pins", {31'h0, pins_oe_n}, 32'h1);
      wb(1'b1, OFS_EXT_WDATA, 32'hBEEF0003);
      // Status is taken on a cycle with the bus phase low
      wb(1'b0, OFS_STATUS, 32'h0);
      check("status_hiz", q, 32'h00000014);
      repeat (10) @(posedge clk_i);
      check("hiz_hold", {31'h0, strb_n}, 32'h1);
      hiz_n <= 1'b1;
      repeat (30) @(posedge clk_i);
      check("hiz_resume", wr_data, 32'hBEEF0003);
      check("keep_back", {31'h0, keep_en}, 32'h1);
      $display("test pin hiz done");
      conclude();
   end
endmodule
